/* pkg/lpmc_pkg.sv */
`default_nettype none
package lpmc_pkg;

	// ****************************************************************
	// register map and field layout
	// ****************************************************************
	localparam int          LPMC_ADDR_W       = 24;
	localparam logic [23:0] LPMC_OPMODE_ADDR  = 24'h0000fa;
	localparam logic [23:0] LPMC_OPERAND_ADDR = 24'h0000fb;
	localparam logic [23:0] LPMC_BUSDRV_ADDR  = 24'h0000fc;
	localparam logic [7:0]  LPMC_OPMODE_RST   = 8'h00;
	localparam logic [7:0]  LPMC_BUSDRV_RST   = 8'h00;
	localparam logic [7:0]  LPMC_BUSDRV_MASK  = 8'h03;

	localparam int LPMC_WP_BIT    = 7;
	localparam int LPMC_DF_LSB    = 3;
	localparam int LPMC_DF_W      = 4;
	localparam int LPMC_BCD_BIT   = 2;
	localparam int LPMC_LPM_LSB   = 0;
	localparam int LPMC_LPM_W     = 2;
	localparam int LPMC_DRVEN_BIT = 0;
	localparam int LPMC_DRVLO_BIT = 1;
	localparam int LPMC_SUPER_BIT = 5;
	localparam int LPMC_IMASK_LSB = 0;
	localparam int LPMC_IMASK_W   = 3;

	localparam logic [2:0] LPMC_FC_SUPER_DATA = 3'h5;

	// ****************************************************************
	// timing counts
	// ****************************************************************
	localparam int          LPMC_DIV_CNT_W    = 15;
	localparam int          LPMC_WAKE_CNT_W   = 17;
	localparam logic [4:0]  LPMC_SETTLE_CLKS  = 5'h10;
	localparam int          LPMC_STOP_TICKS   = 70000;
	localparam logic [16:0] LPMC_DOZE_TICKS   = 17'h009c4;
	localparam logic [16:0] LPMC_STBY_CLKS    = 17'h00002;

	typedef enum logic [1:0] {
		LPMC_MODE_NORMAL  = 2'b00,
		LPMC_MODE_STANDBY = 2'b01,
		LPMC_MODE_DOZE    = 2'b10,
		LPMC_MODE_STOP    = 2'b11
	} lpmc_mode_type;

	typedef enum logic [2:0] {
		LPMC_ST_RUN    = 3'b000,
		LPMC_ST_SETTLE = 3'b001,
		LPMC_ST_REQ    = 3'b010,
		LPMC_ST_DOWN   = 3'b011,
		LPMC_ST_WAKE   = 3'b100
	} lpmc_state_type;

endpackage
`default_nettype wire

/* rtl/lpmc_pow2_div.sv */
`timescale 1ns/1ps
`default_nettype none
module lpmc_pow2_div
	import lpmc_pkg::*;
#(
	parameter int DF_W  = LPMC_DF_W,
	parameter int CNT_W = LPMC_DIV_CNT_W
)(
	input  wire logic            ref_clk_in,
	input  wire logic            rstn_in,
	input  wire logic            clk_en_in,
	input  wire logic            pll_on_in,
	input  wire logic [DF_W-1:0] df_in,
	output logic                 tick_out
);

	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic [CNT_W-1:0] mask;
	logic             tick_q;
	logic             tick_d;

	// ****************************************************************
	// per-bit mask: low df bits must all be set for a tick
	// ****************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < CNT_W; gi++)
		begin : g_mask
			assign mask[gi] = (gi < int'(df_in));
		end
	endgenerate

	// free-running count, so a new factor never stops the clock
	always_comb
	begin
		cnt_d  = cnt_q + 1'b1;
		tick_d = !pll_on_in || ((cnt_q & mask) == mask);
	end

	// register counter and tick
	always_ff @(posedge ref_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			cnt_q  <= '0;
			tick_q <= 1'b0;
		end
		else if (clk_en_in)
		begin
			cnt_q  <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign tick_out = tick_q;

endmodule // lpmc_pow2_div
`default_nettype wire

/* rtl/lpmc_low_power_ctrl.sv */
// Overview of operation
// - stop: oscillator and PLL off, 70000 crystal ticks
// - doze: PLL off, 2500 crystal ticks wake
// - standby: clock gated, wake in few clocks
// - card access wakes section from standby
// - mode field picks normal/standby/doze/stop
// - divide PLL clock by two to df
// - divider only applies with PLL enabled
// - factor change keeps system clock running
// - nonzero factor divides, zero passes undivided
// - write protect bit locks later opmode writes
// - baud bit zero halves baud clock
// - powered down: buses float unless drive enabled
// - drive level bit selects data high/low
// - operand byte write starts power-down request
// - operand bit 5 clear ignores request
// - capture mask; higher interrupt aborts sequence
// - count 16 clocks; grant activity restarts
// - then assert bus request to core
// - after grant enter selected power-down mode
// - wake restarts clocks and releases bus
// - wake during entry abandons the sequence
`timescale 1ns/1ps
`default_nettype none
module lpmc_low_power_ctrl
	import lpmc_pkg::*;
#(
	parameter int STOP_TICKS = LPMC_STOP_TICKS
)(
	input  wire logic                   ref_clk_in,
	input  wire logic                   rstn_in,
	input  wire logic                   clk_en_in,
	input  wire logic [LPMC_ADDR_W-1:0] bus_addr_in,
	input  wire logic [7:0]             bus_wdata_in,
	input  wire logic                   bus_wr_in,
	input  wire logic                   bus_rd_in,
	input  wire logic [2:0]             bus_fc_in,
	input  wire logic                   pll_enable_in,
	input  wire logic                   crystal_tick_in,
	input  wire logic [2:0]             irq_level_in,
	input  wire logic                   bus_grant_in,
	input  wire logic                   bus_grant_acknowledge_in,
	input  wire logic                   wake_event_in,
	input  wire logic                   card_access_in,
	output logic [7:0]                  bus_rdata_out,
	output logic                        bus_request_out,
	output logic                        sys_clk_en_out,
	output logic                        osc_run_out,
	output logic                        pll_run_out,
	output logic                        baud_clk_en_out,
	output logic                        bus_hold_oe_out,
	output logic                        data_hold_level_out,
	output logic [2:0]                  power_state_out
);

	localparam logic [16:0] STOP_TICKS_C = 17'(STOP_TICKS);

	// ****************************************************************
	// register file
	// ****************************************************************
	logic [7:0] opmode_q;
	logic [7:0] opmode_d;
	logic [7:0] busdrv_q;
	logic [7:0] busdrv_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic       wr_opmode;
	logic       wr_busdrv;
	logic       wr_operand;

	assign wr_opmode  = bus_wr_in && (bus_addr_in == LPMC_OPMODE_ADDR);
	assign wr_busdrv  = bus_wr_in && (bus_addr_in == LPMC_BUSDRV_ADDR);
	assign wr_operand = bus_wr_in && (bus_addr_in == LPMC_OPERAND_ADDR);

	// next register values and read data
	always_comb
	begin
		opmode_d = opmode_q;
		busdrv_d = busdrv_q;
		rdata_d  = 8'h00;
		if (wr_opmode && !opmode_q[LPMC_WP_BIT])
			opmode_d = bus_wdata_in;
		if (wr_busdrv)
			busdrv_d = bus_wdata_in & LPMC_BUSDRV_MASK;
		if (bus_rd_in)
		begin
			if (bus_addr_in == LPMC_OPMODE_ADDR)
				rdata_d = opmode_q;
			else if (bus_addr_in == LPMC_BUSDRV_ADDR)
				rdata_d = busdrv_q;
			else
				rdata_d = 8'h00; // unmapped reads as zero
		end
	end

	// register the file
	always_ff @(posedge ref_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			opmode_q <= LPMC_OPMODE_RST;
			busdrv_q <= LPMC_BUSDRV_RST;
			rdata_q  <= 8'h00;
		end
		else if (clk_en_in)
		begin
			opmode_q <= opmode_d;
			busdrv_q <= busdrv_d;
			rdata_q  <= rdata_d;
		end
	end

	// ****************************************************************
	// field decode
	// ****************************************************************
	logic [LPMC_DF_W-1:0] df;
	lpmc_mode_type        mode;
	logic                 bcd;
	logic                 drv_en;
	logic                 drv_lo;

	assign df     = opmode_q[LPMC_DF_LSB +: LPMC_DF_W];
	assign mode   = lpmc_mode_type'(opmode_q[LPMC_LPM_LSB +: LPMC_LPM_W]);
	assign bcd    = opmode_q[LPMC_BCD_BIT];
	assign drv_en = busdrv_q[LPMC_DRVEN_BIT];
	assign drv_lo = busdrv_q[LPMC_DRVLO_BIT];

	// ****************************************************************
	// system clock divider
	// ****************************************************************
	logic div_tick;

	lpmc_pow2_div #(
		.DF_W  (LPMC_DF_W),
		.CNT_W (LPMC_DIV_CNT_W)
	) u_div (
		.ref_clk_in (ref_clk_in),
		.rstn_in    (rstn_in),
		.clk_en_in  (clk_en_in),
		.pll_on_in  (pll_enable_in),
		.df_in      (df),
		.tick_out   (div_tick)
	);

	// ****************************************************************
	// power-down sequencer
	// ****************************************************************
	lpmc_state_type                state_q;
	lpmc_state_type                state_d;
	logic [LPMC_IMASK_W-1:0]       imask_q;
	logic [LPMC_IMASK_W-1:0]       imask_d;
	logic [4:0]                    settle_q;
	logic [4:0]                    settle_d;
	logic [LPMC_WAKE_CNT_W-1:0]    wake_q;
	logic [LPMC_WAKE_CNT_W-1:0]    wake_d;
	lpmc_mode_type                 dmode_q;
	lpmc_mode_type                 dmode_d;
	logic                          abort;
	logic                          wake_now;

	assign abort    = wake_event_in || (irq_level_in > imask_q);
	assign wake_now = wake_event_in
		|| (dmode_q == LPMC_MODE_STANDBY && card_access_in);

	// next sequencer state
	always_comb
	begin
		state_d  = state_q;
		imask_d  = imask_q;
		settle_d = settle_q;
		wake_d   = wake_q;
		dmode_d  = dmode_q;
		case (state_q)
			LPMC_ST_RUN:
			begin
				if (wr_operand && bus_fc_in == LPMC_FC_SUPER_DATA
					&& bus_wdata_in[LPMC_SUPER_BIT])
				begin
					imask_d  = bus_wdata_in[LPMC_IMASK_LSB +: LPMC_IMASK_W];
					settle_d = LPMC_SETTLE_CLKS;
					state_d  = LPMC_ST_SETTLE;
				end
			end
			LPMC_ST_SETTLE:
			begin
				if (abort)
					state_d = LPMC_ST_RUN;
				else if (bus_grant_in || bus_grant_acknowledge_in)
					settle_d = LPMC_SETTLE_CLKS;
				else if (settle_q == 5'h01)
					state_d = LPMC_ST_REQ;
				else
					settle_d = settle_q - 5'h01;
			end
			LPMC_ST_REQ:
			begin
				if (abort)
					state_d = LPMC_ST_RUN;
				else if (bus_grant_in)
				begin
					dmode_d = mode;
					state_d = (mode == LPMC_MODE_NORMAL) ? LPMC_ST_RUN : LPMC_ST_DOWN;
				end
			end
			LPMC_ST_DOWN:
			begin
				if (wake_now)
				begin
					state_d = LPMC_ST_WAKE;
					case (dmode_q)
						LPMC_MODE_STOP:  wake_d = STOP_TICKS_C;
						LPMC_MODE_DOZE:  wake_d = LPMC_DOZE_TICKS;
						default:         wake_d = LPMC_STBY_CLKS;
					endcase
				end
			end
			LPMC_ST_WAKE:
			begin
				if (wake_q <= 17'h00001)
					state_d = LPMC_ST_RUN;
				else if (dmode_q == LPMC_MODE_STANDBY || crystal_tick_in)
					wake_d = wake_q - 17'h00001;
			end
			default:
				state_d = LPMC_ST_RUN;
		endcase
	end

	// register sequencer
	always_ff @(posedge ref_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			state_q  <= LPMC_ST_RUN;
			imask_q  <= '0;
			settle_q <= 5'h00;
			wake_q   <= '0;
			dmode_q  <= LPMC_MODE_NORMAL;
		end
		else if (clk_en_in)
		begin
			state_q  <= state_d;
			imask_q  <= imask_d;
			settle_q <= settle_d;
			wake_q   <= wake_d;
			dmode_q  <= dmode_d;
		end
	end

	// ****************************************************************
	// output stage
	// ****************************************************************
	logic       breq_d;
	logic       breq_q;
	logic       sclk_d;
	logic       sclk_q;
	logic       osc_d;
	logic       osc_q;
	logic       pll_d;
	logic       pll_q;
	logic       bhalf_d;
	logic       bhalf_q;
	logic       baud_d;
	logic       baud_q;
	logic       hold_d;
	logic       hold_q;
	logic       lvl_d;
	logic       lvl_q;
	logic       down;

	assign down = (state_d == LPMC_ST_DOWN);

	// next output values
	always_comb
	begin
		breq_d  = (state_d == LPMC_ST_REQ) || down
			|| (state_d == LPMC_ST_WAKE);
		sclk_d  = div_tick && !down && (state_d != LPMC_ST_WAKE);
		osc_d   = !(down && dmode_d == LPMC_MODE_STOP);
		pll_d   = pll_enable_in && !(down && (dmode_d == LPMC_MODE_STOP
			|| dmode_d == LPMC_MODE_DOZE));
		bhalf_d = !bhalf_q;
		baud_d  = bcd || bhalf_q;
		hold_d  = down && drv_en;
		lvl_d   = !drv_lo;
	end

	// register outputs
	always_ff @(posedge ref_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			breq_q  <= 1'b0;
			sclk_q  <= 1'b0;
			osc_q   <= 1'b1;
			pll_q   <= 1'b0;
			bhalf_q <= 1'b0;
			baud_q  <= 1'b0;
			hold_q  <= 1'b0;
			lvl_q   <= 1'b1;
		end
		else if (clk_en_in)
		begin
			breq_q  <= breq_d;
			sclk_q  <= sclk_d;
			osc_q   <= osc_d;
			pll_q   <= pll_d;
			bhalf_q <= bhalf_d;
			baud_q  <= baud_d;
			hold_q  <= hold_d;
			lvl_q   <= lvl_d;
		end
	end

	assign bus_rdata_out       = rdata_q;
	assign bus_request_out     = breq_q;
	assign sys_clk_en_out      = sclk_q;
	assign osc_run_out         = osc_q;
	assign pll_run_out         = pll_q;
	assign baud_clk_en_out     = baud_q;
	assign bus_hold_oe_out     = hold_q;
	assign data_hold_level_out = lvl_q;
	assign power_state_out     = state_q;

endmodule // lpmc_low_power_ctrl
`default_nettype wire

/* test/lpmc_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// power-down sequence checker
// ****************************************************************
module lpmc_monitor
	import lpmc_pkg::*;
(
	input  wire logic                   ref_clk_in,
	input  wire logic                   rstn_in,
	input  wire logic                   clk_en_in,
	input  wire logic [LPMC_ADDR_W-1:0] bus_addr_in,
	input  wire logic [7:0]             bus_wdata_in,
	input  wire logic                   bus_wr_in,
	input  wire logic [2:0]             bus_fc_in,
	input  wire logic [2:0]             irq_level_in,
	input  wire logic                   bus_grant_acknowledge_in,
	input  wire logic                   wake_event_in,
	input  wire logic                   bus_request_out,
	input  wire logic                   sys_clk_en_out,
	input  wire logic                   osc_run_out,
	input  wire logic                   pll_run_out,
	input  wire logic [2:0]             power_state_out
);
	logic op_wr;

	// operand write that may open a power-down request
	assign op_wr = clk_en_in && bus_wr_in && bus_addr_in == LPMC_OPERAND_ADDR
		&& bus_fc_in == LPMC_FC_SUPER_DATA && power_state_out == 3'h0 && !wake_event_in;

	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!rstn_in);

	AST_START: assert property (op_wr && bus_wdata_in[LPMC_SUPER_BIT] |=> power_state_out == 3'h1)
		else $error("operand write did not start settling");
	AST_IGNORE: assert property (op_wr && !bus_wdata_in[LPMC_SUPER_BIT] |=> power_state_out == 3'h0)
		else $error("user operand write was not ignored");
	AST_COUNT: assert property (power_state_out == 3'h2 && $past(power_state_out) == 3'h1
		|-> $past(power_state_out, 16) == 3'h1)
		else $error("request raised before 16 settle clocks");
	AST_RELOAD: assert property (clk_en_in && power_state_out == 3'h1 && bus_grant_acknowledge_in
		&& !wake_event_in && irq_level_in == 3'h0 |=> power_state_out == 3'h1)
		else $error("grant activity did not hold the settle count");
	AST_REQ: assert property ($rose(power_state_out == 3'h2) |=> bus_request_out)
		else $error("bus request missing after settle count");
	AST_ABORT: assert property (clk_en_in && wake_event_in && power_state_out == 3'h1
		|=> power_state_out == 3'h0)
		else $error("wake during entry did not abort");
	AST_GATED: assert property (power_state_out == 3'h3 && $past(power_state_out) == 3'h3
		|-> !sys_clk_en_out)
		else $error("system clock running while powered down");
	AST_HOLD: assert property (power_state_out == 3'h3 |-> bus_request_out)
		else $error("bus released while powered down");
	AST_OSC: assert property (!osc_run_out |-> !pll_run_out)
		else $error("pll running with oscillator stopped");
endmodule // lpmc_monitor

bind lpmc_low_power_ctrl lpmc_monitor lpmc_monitor_inst (.ref_clk_in, .rstn_in, .clk_en_in,
	.bus_addr_in, .bus_wdata_in, .bus_wr_in, .bus_fc_in, .irq_level_in, .bus_grant_acknowledge_in,
	.wake_event_in, .bus_request_out, .sys_clk_en_out, .osc_run_out, .pll_run_out,
	.power_state_out);
`default_nettype wire

/* test/lpmc_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// core side: grants a held bus request after a chosen delay
// ****************************************************************
module lpmc_core_model (
	input  wire logic       ref_clk_in,
	input  wire logic       rstn_in,
	input  wire logic       bus_request_in,
	input  wire logic [3:0] grant_delay_in,
	output logic            bus_grant_out
);
	logic [3:0] wait_q;

	// count how long the request has stood, cleared when it drops
	always_ff @(posedge ref_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			wait_q <= 4'h0;
		else if (!bus_request_in)
			wait_q <= 4'h0;
		else if (wait_q != 4'hf)
			wait_q <= wait_q + 4'h1;
	end

	// grant only while the request stands, never before one clock
	assign bus_grant_out = bus_request_in && wait_q > grant_delay_in;
endmodule // lpmc_core_model
`default_nettype wire

/* test/tb_lpmc_low_power_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// register and power-down sequence bench
// ****************************************************************
module tb_lpmc_low_power_ctrl;
	import lpmc_pkg::*;
	localparam int STOP_T = 20;
	logic        ref_clk_in, rstn_in, clk_en_in, bus_wr_in, bus_rd_in, pll_enable_in;
	logic        crystal_tick_in, bus_grant_in, bus_grant_acknowledge_in, wake_event_in;
	logic        card_access_in, bus_request_out, sys_clk_en_out, osc_run_out, pll_run_out;
	logic        baud_clk_en_out, bus_hold_oe_out, data_hold_level_out;
	logic [23:0] bus_addr_in;
	logic [7:0]  bus_wdata_in, bus_rdata_out;
	logic [2:0]  bus_fc_in, irq_level_in, power_state_out;
	logic [3:0]  grant_delay;
	int          err_total, cmp_count, n, lim;

	lpmc_low_power_ctrl #(.STOP_TICKS(STOP_T)) lpmc_low_power_ctrl_inst (.ref_clk_in, .rstn_in,
		.clk_en_in, .bus_addr_in, .bus_wdata_in, .bus_wr_in, .bus_rd_in, .bus_fc_in, .pll_enable_in,
		.crystal_tick_in, .irq_level_in, .bus_grant_in, .bus_grant_acknowledge_in, .wake_event_in,
		.card_access_in, .bus_rdata_out, .bus_request_out, .sys_clk_en_out, .osc_run_out,
		.pll_run_out, .baud_clk_en_out, .bus_hold_oe_out, .data_hold_level_out, .power_state_out);
	lpmc_core_model lpmc_core_model_inst (.ref_clk_in, .rstn_in, .bus_request_in(bus_request_out),
		.grant_delay_in(grant_delay), .bus_grant_out(bus_grant_in));

	// system clock
	initial
	begin
		ref_clk_in = 1'b0;
		forever #5 ref_clk_in = ~ref_clk_in;
	end
	// crystal ticks every other system clock, quiet while in reset
	always @(posedge ref_clk_in) crystal_tick_in <= rstn_in && !crystal_tick_in;

	task automatic check(input logic [16:0] got, input logic [16:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("mismatches %0d compares %0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [2:0] fc);
		@(posedge ref_clk_in);
		bus_addr_in <= {16'h0000, a};
		bus_wdata_in <= d;
		bus_fc_in <= fc;
		bus_wr_in <= 1'b1;
		@(posedge ref_clk_in);
		bus_wr_in <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		@(posedge ref_clk_in);
		bus_addr_in <= {16'h0000, a};
		bus_rd_in <= 1'b1;
		@(posedge ref_clk_in);
		bus_rd_in <= 1'b0;
		#1 check(bus_rdata_out, exp);
	endtask
	// count clock-enable pulses of system or baud clock over c cycles
	task automatic cnt(input bit baud, input int c, input logic [16:0] exp);
		int k;
		k = 0;
		// skip the cycles in which a new setting is still reaching the output
		repeat (2) @(posedge ref_clk_in);
		repeat (c)
		begin
			@(posedge ref_clk_in);
			#1 k += baud ? baud_clk_en_out : sys_clk_en_out;
		end
		check(k, exp);
	endtask
	task automatic wait_st(input logic [2:0] st, input bit eq, output int w);
		w = 0;
		#1;
		while ((power_state_out === st) != eq)
		begin
			@(posedge ref_clk_in);
			#1 w++;
			if (w > 20000)
			begin
				err_total++;
				finish_test();
			end
		end
	endtask

	// main sequence
	initial
	begin
		{rstn_in, bus_wr_in, bus_rd_in, bus_grant_acknowledge_in} = '0;
		{wake_event_in, card_access_in, bus_addr_in, bus_wdata_in, irq_level_in} = '0;
		{clk_en_in, pll_enable_in, bus_fc_in, grant_delay, err_total, cmp_count} = '0;
		clk_en_in = 1'b1;
		pll_enable_in = 1'b1;
		repeat (20) @(posedge ref_clk_in);
		rstn_in <= 1'b1;
		rdc(8'hfa, 8'h00);
		rdc(8'hfc, 8'h00);
		rdc(8'hf0, 8'h00);
		check(osc_run_out, 1'b1);
		cnt(0, 32, 32);
		wr(8'hfa, 8'h0c, 3'h5);
		cnt(0, 32, 16);
		cnt(1, 32, 32);
		wr(8'hfa, 8'h08, 3'h5);
		cnt(1, 32, 16);
		pll_enable_in <= 1'b0;
		cnt(0, 32, 32);
		pll_enable_in <= 1'b1;
		wr(8'hfa, 8'h78, 3'h5);
		cnt(0, 65536, 2);
		wr(8'hfa, 8'h00, 3'h5);
		wr(8'hfb, 8'h07, 3'h5);
		#1 check(power_state_out, 3'h0);
		wr(8'hfb, 8'h27, 3'h3);
		#1 check(power_state_out, 3'h0);
		irq_level_in <= 3'h3;
		wr(8'hfb, 8'h22, 3'h5);
		wait_st(3'h0, 1, n);
		check(n <= 3, 1'b1);
		irq_level_in <= 3'h0;
		wr(8'hfb, 8'h27, 3'h5);
		wake_event_in <= 1'b1;
		wait_st(3'h0, 1, n);
		check(n <= 3, 1'b1);
		@(posedge ref_clk_in) wake_event_in <= 1'b0;
		wr(8'hfb, 8'h27, 3'h5);
		repeat (5) @(posedge ref_clk_in);
		bus_grant_acknowledge_in <= 1'b1;
		@(posedge ref_clk_in) bus_grant_acknowledge_in <= 1'b0;
		wait_st(3'h2, 1, n);
		check(n >= 14 && n <= 18, 1'b1);
		wait_st(3'h0, 1, n);
		// each mode, with drive enable and level taken from the mode bits
		for (int m = 0; m < 4; m++)
		begin
			grant_delay <= 4'(m * 3);
			wr(8'hfc, 8'(m), 3'h5);
			wr(8'hfa, 8'(m), 3'h5);
			wr(8'hfb, 8'h27, 3'h5);
			wait_st(3'h2, 1, n);
			check(n, 16);
			check(bus_request_out, 1'b1);
			#10 check(bus_request_out, 1'b1);
			wait_st(3'h2, 0, n);
			check(power_state_out, m == 0 ? 0 : 3);
			if (m != 0)
			begin
				@(posedge ref_clk_in);
				#1 check(osc_run_out, m != 3);
				check(pll_run_out, m == 1);
				check(sys_clk_en_out, 1'b0);
				check(bus_hold_oe_out, m[0]);
				check(data_hold_level_out, !m[1]);
				@(posedge ref_clk_in);
				card_access_in <= m == 1;
				wake_event_in <= m != 1;
				@(posedge ref_clk_in);
				{card_access_in, wake_event_in} <= 2'b00;
				lim = m == 3 ? STOP_T : m == 2 ? 2500 : 2;
				wait_st(3'h0, 1, n);
				check(n >= 2 * lim - 4 && n <= 2 * lim + 6, 1'b1);
			end
			@(posedge ref_clk_in);
			#1 check(bus_request_out, 1'b0);
		end
		wr(8'hfc, 8'hff, 3'h5);
		rdc(8'hfc, 8'h03);
		wr(8'hfa, 8'h80, 3'h5);
		wr(8'hfa, 8'h0c, 3'h5);
		rdc(8'hfa, 8'h80);
		finish_test();
	end
endmodule // tb_lpmc_low_power_ctrl
`default_nettype wire
